// [hw/dcd_regs.svh]
// Register offsets, field positions, command codes and reset values for the dual sink DAC control
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

// Serial command word layout, first bit received lands in the top bit
`define DCD_WORD_W 16
`define DCD_CC_HI 15
`define DCD_CC_LO 12
`define DCD_CODE_HI 11
`define DCD_CODE_LO 2
`define DCD_SPARE_HI 1
`define DCD_SPARE_LO 0
`define DCD_BIT_CNT_W 4
`define DCD_BIT_LAST 4'hF
`define DCD_BIT_ONE 4'h1
`define DCD_BIT_ZERO 4'h0

// Control codes
`define DCD_CC_EXT_REF 4'h0
`define DCD_CC_INT_REF 4'h8
`define DCD_CC_A_LO 4'h2
`define DCD_CC_A_HI 4'h3
`define DCD_CC_B_LO 4'h4
`define DCD_CC_B_HI 4'h5
`define DCD_CC_AB_LO 4'h6
`define DCD_CC_AB_HI 4'h7

// Power-up values
`define DCD_CODE_RST 10'h000
`define DCD_RANGE_RST 1'h0
`define DCD_REF_RST 1'h0
`define DCD_SPARE_OK 2'h0

// Software register map
`define DCD_ADDR_W 8
`define DCD_DATA_W 32
`define DCD_OFF_CTRL 8'h00
`define DCD_OFF_CHAN_A 8'h04
`define DCD_OFF_CHAN_B 8'h08
`define DCD_OFF_STATUS 8'h0C
`define DCD_OFF_WORDS 8'h10
`define DCD_OFF_LAST 8'h14

// Field positions
`define DCD_CTRL_HOLD 0
`define DCD_ST_REF 0
`define DCD_ST_FS_A 1
`define DCD_ST_FS_B 2
`define DCD_ST_ABORT 3
`define DCD_ST_RSVD 4
`define DCD_ST_SPARE 5
`define DCD_ST_STATE_LO 6
`define DCD_ST_STATE_HI 8
`define DCD_CNT_W 16
`define DCD_CNT_RST 16'h0000
`define DCD_CNT_ONE 16'h0001
`define DCD_DATA_ZERO 32'h0000_0000

`endif

// [hw/dcd_pkg.sv]
// Types shared by the dual sink DAC control block
package dcd_pkg;

  typedef logic [9:0] dcd_code_t;

  typedef logic [15:0] dcd_word_t;

  typedef enum logic [2:0] {
    DCD_ST_IDLE = 3'h1,
    DCD_ST_FRAME = 3'h2,
    DCD_ST_DONE = 3'h4
  } dcd_state_t;

endpackage

// [hw/dcd_shift.sv]
// Serial-clock side: 16-bit input shift register and bit counter
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_shift
  import dcd_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  output dcd_pkg::dcd_word_t word,
  output logic done
);

  logic [`DCD_BIT_CNT_W-1:0] bit_cnt;
  dcd_word_t shreg;
  wire last_bit = (bit_cnt == `DCD_BIT_LAST) && !done;
  wire dcd_word_t next_word = {shreg[`DCD_WORD_W-2:0], sdi};

  // Select high clears the count, so a partial word is dropped
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      bit_cnt <= `DCD_BIT_ZERO;
      done <= 1'b0;
    end else begin
      if (!done) begin
        bit_cnt <= bit_cnt + `DCD_BIT_ONE;
      end
      if (last_bit) begin
        done <= 1'b1;
      end
    end
  end

  // Data sampled on the falling edge, first bit shifts to the top
  always_ff @(negedge sclk) begin
    if (!cs_b) begin
      shreg <= next_word;
    end
  end

  // Completed word held until the next full word
  always_ff @(negedge sclk) begin
    if (!cs_b && last_bit) begin
      word <= next_word;
    end
  end

endmodule // dcd_shift

// [hw/dcd_top.sv]
// Dual 10-bit current-sink DAC serial command front end with software status port
//
// Contract
// - Data sampled on falling serial clock edges
// - Either clock idle level is accepted
// - Sixteen-bit word, first four bits control code
// - Next ten bits are code, MSB first
// - Registers update on sixteenth falling edge; channel registers here load on the third rising clk edge after it
// - Code 0000 selects external reference only
// - Code 1000 selects internal reference only
// - Codes 0010/0011 load A, low/high range
// - Codes 0100/0101 load B, low/high range
// - Codes 0110/0111 load both, low/high range
// - Power-up: external reference, low ranges, zero
// - Channel code is straight binary
// - Shift register feeds two channel registers
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "dcd_regs.svh"

module dcd_top
  import dcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic sdi,
  input wire logic [`DCD_ADDR_W-1:0] reg_addr,
  input wire logic [`DCD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DCD_DATA_W-1:0] reg_rdata,
  output dcd_pkg::dcd_code_t channel_a_sink,
  output dcd_pkg::dcd_code_t channel_b_sink,
  output logic full_scale_current_a,
  output logic full_scale_current_b,
  output logic ref_internal
);

  import dcd_pkg::*;

  dcd_word_t word;
  logic done;

  dcd_shift u_shift (
    .sclk(sclk),
    .cs_b(cs_b),
    .sdi(sdi),
    .word(word),
    .done(done)
  );

  // Crossing into the system clock: two flops per level
  logic cs_meta;
  logic cs_sync;
  logic done_meta;
  logic done_sync;
  logic done_prev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      cs_meta <= cs_b;
      cs_sync <= cs_meta;
      done_meta <= done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  wire done_rise = done_sync && !done_prev;

  // Word decode
  wire [3:0] control_code = word[`DCD_CC_HI:`DCD_CC_LO];
  wire dcd_code_t code_field = word[`DCD_CODE_HI:`DCD_CODE_LO];
  wire [1:0] spare_bits = word[`DCD_SPARE_HI:`DCD_SPARE_LO];
  wire cc_ext = (control_code == `DCD_CC_EXT_REF);
  wire cc_int = (control_code == `DCD_CC_INT_REF);
  wire cc_a_lo = (control_code == `DCD_CC_A_LO);
  wire cc_a_hi = (control_code == `DCD_CC_A_HI);
  wire cc_b_lo = (control_code == `DCD_CC_B_LO);
  wire cc_b_hi = (control_code == `DCD_CC_B_HI);
  wire cc_ab_lo = (control_code == `DCD_CC_AB_LO);
  wire cc_ab_hi = (control_code == `DCD_CC_AB_HI);
  wire load_a = cc_a_lo || cc_a_hi || cc_ab_lo || cc_ab_hi;
  wire load_b = cc_b_lo || cc_b_hi || cc_ab_lo || cc_ab_hi;
  wire range_hi = cc_a_hi || cc_b_hi || cc_ab_hi;
  wire cc_valid = cc_ext || cc_int || load_a || load_b;
  wire spare_bad = (spare_bits != `DCD_SPARE_OK);

  // Control register
  logic hold;
  wire sel_ctrl = (reg_addr == `DCD_OFF_CTRL);
  wire sel_chan_a = (reg_addr == `DCD_OFF_CHAN_A);
  wire sel_chan_b = (reg_addr == `DCD_OFF_CHAN_B);
  wire sel_status = (reg_addr == `DCD_OFF_STATUS);
  wire sel_words = (reg_addr == `DCD_OFF_WORDS);
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_status = reg_wr && sel_status;

  // Frame tracking
  dcd_state_t state;
  dcd_state_t next_state;
  wire word_in = (state == DCD_ST_FRAME) && done_rise;
  wire apply = word_in && cc_valid && !hold;
  wire abort_ev = (state == DCD_ST_FRAME) && cs_sync && !done_rise;
  wire rsvd_ev = word_in && !cc_valid;
  wire spare_ev = word_in && spare_bad;

  always_comb begin
    next_state = state;
    unique case (state)
      DCD_ST_IDLE: begin
        if (!cs_sync) begin
          next_state = DCD_ST_FRAME;
        end
      end
      DCD_ST_FRAME: begin
        if (done_rise) begin
          next_state = DCD_ST_DONE;
        end else if (cs_sync) begin
          next_state = DCD_ST_IDLE;
        end
      end
      DCD_ST_DONE: begin
        if (cs_sync) begin
          next_state = DCD_ST_IDLE;
        end
      end
      default: begin
        next_state = DCD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= DCD_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Channel registers, ranges and reference mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_a_sink <= `DCD_CODE_RST;
      channel_b_sink <= `DCD_CODE_RST;
      full_scale_current_a <= `DCD_RANGE_RST;
      full_scale_current_b <= `DCD_RANGE_RST;
      ref_internal <= `DCD_REF_RST;
    end else if (apply) begin
      if (load_a) begin
        channel_a_sink <= code_field;
        full_scale_current_a <= range_hi;
      end
      if (load_b) begin
        channel_b_sink <= code_field;
        full_scale_current_b <= range_hi;
      end
      if (cc_ext) begin
        ref_internal <= 1'b0;
      end
      if (cc_int) begin
        ref_internal <= 1'b1;
      end
    end
  end

  // Sticky event flags: write one to clear, a new event wins
  logic abort_seen;
  logic rsvd_seen;
  logic spare_seen;
  logic [`DCD_CNT_W-1:0] word_cnt;
  wire clr_abort = wr_status && reg_wdata[`DCD_ST_ABORT];
  wire clr_rsvd = wr_status && reg_wdata[`DCD_ST_RSVD];
  wire clr_spare = wr_status && reg_wdata[`DCD_ST_SPARE];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hold <= 1'b0;
      abort_seen <= 1'b0;
      rsvd_seen <= 1'b0;
      spare_seen <= 1'b0;
      word_cnt <= `DCD_CNT_RST;
    end else begin
      if (wr_ctrl) begin
        hold <= reg_wdata[`DCD_CTRL_HOLD];
      end
      abort_seen <= abort_ev || (abort_seen && !clr_abort);
      rsvd_seen <= rsvd_ev || (rsvd_seen && !clr_rsvd);
      spare_seen <= spare_ev || (spare_seen && !clr_spare);
      if (apply) begin
        word_cnt <= word_cnt + `DCD_CNT_ONE;
      end
    end
  end

  // Read mux; unmapped offsets read zero
  logic [`DCD_DATA_W-1:0] status_word;
  logic [`DCD_DATA_W-1:0] read_mux;

  always_comb begin
    status_word = `DCD_DATA_ZERO;
    status_word[`DCD_ST_REF] = ref_internal;
    status_word[`DCD_ST_FS_A] = full_scale_current_a;
    status_word[`DCD_ST_FS_B] = full_scale_current_b;
    status_word[`DCD_ST_ABORT] = abort_seen;
    status_word[`DCD_ST_RSVD] = rsvd_seen;
    status_word[`DCD_ST_SPARE] = spare_seen;
    status_word[`DCD_ST_STATE_HI:`DCD_ST_STATE_LO] = state;
  end

  always_comb begin
    read_mux = `DCD_DATA_ZERO;
    if (sel_ctrl) begin
      read_mux[`DCD_CTRL_HOLD] = hold;
    end
    if (sel_chan_a) begin
      read_mux[9:0] = channel_a_sink;
    end
    if (sel_chan_b) begin
      read_mux[9:0] = channel_b_sink;
    end
    if (sel_status) begin
      read_mux = status_word;
    end
    if (sel_words) begin
      read_mux[`DCD_CNT_W-1:0] = word_cnt;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= `DCD_DATA_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= `DCD_DATA_ZERO;
    end
  end

endmodule // dcd_top

// [test/dcd_top_chk.sv]
// Port-level concurrent checks for the dual sink DAC control
`timescale 1ns/1ps
module dcd_top_chk
  import dcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire dcd_pkg::dcd_code_t channel_a_sink,
  input wire dcd_pkg::dcd_code_t channel_b_sink,
  input wire logic full_scale_current_a,
  input wire logic full_scale_current_b,
  input wire logic ref_internal
);
  import dcd_pkg::*;
  wire [22:0] outs = {ref_internal, full_scale_current_b, full_scale_current_a,
    channel_b_sink, channel_a_sink};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside its slot");
  a_reset_state: assert property (disable iff (1'h0) !rst_b |=> outs == 23'h0)
    else $error("outputs not at power-up values");
  a_read_chan_a: assert property (reg_rd && reg_addr == 8'h04 |=>
    reg_rdata == {22'h0, $past(channel_a_sink)}) else $error("channel A readback wrong");
  a_read_chan_b: assert property (reg_rd && reg_addr == 8'h08 |=>
    reg_rdata == {22'h0, $past(channel_b_sink)}) else $error("channel B readback wrong");
  a_read_status: assert property (reg_rd && reg_addr == 8'h0C |=>
    reg_rdata[2:0] == $past({full_scale_current_b, full_scale_current_a, ref_internal}))
    else $error("status mode bits wrong");
  a_quiet_link: assert property (cs_b [*6] |-> $stable(outs))
    else $error("outputs moved with the link idle");
  a_ref_alone: assert property ($changed(ref_internal) |-> $stable(outs[21:0]))
    else $error("reference command touched a channel");
  a_both_equal: assert property ($changed(channel_a_sink) && $changed(channel_b_sink)
    |-> channel_a_sink == channel_b_sink) else $error("joint load differs");
endmodule // dcd_top_chk

bind dcd_top dcd_top_chk u_chk (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .channel_a_sink(channel_a_sink), .channel_b_sink(channel_b_sink),
  .full_scale_current_a(full_scale_current_a),
  .full_scale_current_b(full_scale_current_b), .ref_internal(ref_internal));

// [test/dcd_master.sv]
// Serial master model driving select, clock and data
`timescale 1ns/1ps
module dcd_master (
  output logic sclk,
  output logic cs_b,
  output logic sdi
);
  initial begin
    sclk = 1'h0;
    cs_b = 1'h0;
    sdi = 1'h0;
    #1;
    // Clean rising edge of select clears the serial bit counter
    cs_b = 1'h1;
  end
  // Sends the top n bits of w; h is half the clock period in ns
  task automatic send(input logic [15:0] w, input int n, input logic cpol, input int h);
    sclk = cpol;
    #40;
    cs_b = 1'h0;
    #30;
    for (int i = 15; i > 15 - n; i--) begin
      if (!cpol) sclk = 1'h1;
      sdi = w[i];
      #h;
      sclk = 1'h0;
      #h;
      if (cpol) sclk = 1'h1;
    end
    #60;
    cs_b = 1'h1;
    sdi = ~sdi;
    #120;
  endtask
endmodule // dcd_master

// [test/dcd_top_bench.sv]
// Self-checking bench for the dual sink DAC control
`timescale 1ns/1ps
module dcd_top_bench;
  import dcd_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, fa, fb, rf, efa, efb, erf;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire sclk, cs_b, sdi;
  dcd_code_t cha, chb, ea, eb;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  dcd_top dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .sdi(sdi),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_a_sink(cha), .channel_b_sink(chb),
    .full_scale_current_a(fa), .full_scale_current_b(fb), .ref_internal(rf));
  dcd_master master (.sclk(sclk), .cs_b(cs_b), .sdi(sdi));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_out();
    @(negedge clk);
    chk_reg({9'h0, rf, fb, fa, chb, cha}, {9'h0, erf, efb, efa, eb, ea});
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(negedge clk);
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk_reg(reg_rdata, exp);
  endtask
  // Sends a whole word, then updates the expected outputs and compares
  task automatic frame(input logic [15:0] w, input logic cpol);
    master.send(w, 16, cpol, 15);
    if (!w[15] && w[13]) begin
      ea = w[11:2];
      efa = w[12];
    end
    if (!w[15] && w[14]) begin
      eb = w[11:2];
      efb = w[12];
    end
    if (w[14:12] == 3'h0) erf = w[15];
    chk_out();
  endtask
  task automatic t_all_loads();
    logic [9:0] val [6] = '{10'h3FF, 10'h001, 10'h200, 10'h155, 10'h000, 10'h2AA};
    for (int i = 0; i < 6; i++) begin
      frame({4'(i + 2), val[i], 2'h0}, i[0]);
    end
  endtask
  task automatic t_ref();
    frame(16'h8FFC, 1'h0);
    frame(16'h0554, 1'h1);
    frame(16'h8000, 1'h1);
  endtask
  task automatic t_abort();
    master.send(16'h2FFC, 15, 1'h0, 60);
    chk_out();
    reg_check(8'h0C, {23'h0, 3'h1, 2'h0, 1'h1, efb, efa, erf});
    reg_write(8'h0C, 32'h8);
    frame(16'h7804, 1'h0);
  endtask
  task automatic t_regs();
    reg_check(8'h04, {22'h0, ea});
    reg_check(8'h08, {22'h0, eb});
    reg_write(8'h04, 32'h3FF);
    reg_check(8'h04, {22'h0, ea});
    reg_check(8'h20, 32'h0);
    reg_write(8'h00, 32'h1);
    reg_check(8'h00, 32'h1);
    master.send(16'h23FC, 16, 1'h0, 15);
    chk_out();
    reg_write(8'h00, 32'h0);
    master.send(16'h9FFC, 16, 1'h1, 15);
    chk_out();
    reg_check(8'h0C, {23'h0, 3'h1, 2'h1, 1'h0, efb, efa, erf});
    frame(16'h3FFF, 1'h0);
    reg_check(8'h0C, {23'h0, 3'h1, 2'h3, 1'h0, efb, efa, erf});
    reg_check(8'h10, 32'hB);
  endtask
  initial begin
    rst_b = 1'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    {ea, eb, efa, efb, erf} = 23'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    chk_out();
    reg_check(8'h0C, 32'h40);
    t_all_loads();
    t_ref();
    t_abort();
    t_regs();
    tally_and_finish();
  end
endmodule // dcd_top_bench
